// *** verilog/dsf_pkg.sv ***
package dsf_pkg;
	// ****************************************
	// Commands (octal codes)
	// ****************************************
	localparam logic [5:0] DSF_CMD_FORMAT = 6'o63;
	localparam logic [5:0] DSF_CMD_WRITE = 6'o61;
	localparam logic [5:0] DSF_CMD_READ_HDR = 6'o73;
	localparam logic [5:0] DSF_CMD_READ = 6'o71;
	localparam logic [5:0] DSF_CMD_SEEK = 6'o05;
	localparam logic [5:0] DSF_CMD_SEARCH = 6'o31;
	// ****************************************
	// Register map (word aligned byte addresses)
	// ****************************************
	localparam logic [3:0] DSF_ADDR_CMD = 4'h0;
	localparam logic [3:0] DSF_ADDR_CYL = 4'h4;
	localparam logic [3:0] DSF_ADDR_SECTRK = 4'h8;
	localparam logic [3:0] DSF_ADDR_STATUS = 4'hc;
	// ****************************************
	// Format figures
	// ****************************************
	localparam int DSF_CYL_WIDTH = 10;
	localparam logic [9:0] DSF_CYL_MAX = 10'h19a;
	localparam logic [7:0] DSF_SYNC_BYTE = 8'h98;
	localparam logic [9:0] DSF_BYTE_PRE_SYNC = 10'h027;
	localparam logic [9:0] DSF_BYTE_ARM = 10'h01e;
	localparam logic [9:0] DSF_HDR_GAP_ZEROS = 10'h00b;
	localparam logic [9:0] DSF_HDR_BYTES = 10'h00a;
	localparam logic [9:0] DSF_DATA_WORDS = 10'h100;
	localparam logic [9:0] DSF_ECC_BYTES = 10'h004;
	localparam logic [9:0] DSF_DGAP_BYTES = 10'h002;
	localparam logic [9:0] DSF_TOL_BYTES = 10'h01c;
	localparam real DSF_TOL_US = 34.72;
	localparam real DSF_CLK_MHZ = 40.0;
	localparam int DSF_TOL_CYCLES = int'(DSF_TOL_US * DSF_CLK_MHZ);
	localparam logic [4:0] DSF_SECT_16 = 5'h16;
	localparam logic [4:0] DSF_SECT_18 = 5'h14;
	localparam int DSF_SEC_LO = 0;
	localparam int DSF_TRK_LO = 8;
	localparam int DSF_ST_FORMAT18 = 0;

	typedef enum logic [7:0]
	{
		DSF_IDLE = 8'h01,
		DSF_PRE = 8'h02,
		DSF_HDR = 8'h04,
		DSF_HGAP = 8'h08,
		DSF_DATA = 8'h10,
		DSF_ECC = 8'h20,
		DSF_DGAP = 8'h40,
		DSF_TOL = 8'h80
	} dsf_state_t;

	typedef struct packed
	{
		logic format;
		logic wr_data;
		logic rd_hdr;
		logic rd_data;
	} dsf_cmd_t;
endpackage

// *** verilog/dsf_sequencer.sv ***
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Load cylinder on seek, implied seek of read/write, and extended advance.
// - Desired cylinder register is ten bits, one spare, reaching 411 cylinders.
// - Each read/write or search uses sector and track address for headers; the code matches only the sector address, against the sector count.
// - Search with cylinder and track selected only signals sector arrival.
// - Header gap is twelve bytes: eleven zeros then one sync byte.
// - Data field holds at most 256 words in both word formats.
// - Eighteen-bit mode divides track into only twenty sectors.
// - Two error-code words follow data, generated while writing; the code writes four zero bytes there.
// - Two zero bytes follow error words as data gap.
// - Tolerance gap of 28 bytes, about 34.72 us, closes each sector.
// - Four sector commands: octal 63, 61, 73, 71.
// - Sector pulse advances sector counter and clears byte counter.
// - Formatting sector pulse clears data shift register, writing zeros.
// - Formatting sector pulse sets sector-found and format flags.
// - Other commands set sector-found only when sector count matches desired.
// - Formatting sends sync clock; controller write clock strobes header word in.
// - Formatting writes zeros until byte 39, then inserts sync byte.
// - Loading the sync byte clears the byte counter.
// - At byte 39 formatting pulses buffer clock capturing first header word.
// - Non-format commands at byte 30 set read-enable and sync-strobe flags.
// - Non-format sync detection sets header-area flag.
// - Non-format sync detection clears byte counter.
// - Pre-header field is 39 zero bytes then sync pattern 1001 1000.
// - Second header word: sector in bits 0-4, track in bits 8-12.
module dsf_sequencer
	import dsf_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic wb_we_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic sector_pulse_in,
	input wire logic byte_clock_in,
	input wire logic [7:0] read_byte_in,
	input wire logic [15:0] data_lines_in,
	input wire logic controller_write_clock_in,
	input wire logic cyl_advance_in,
	output logic [7:0] write_byte_out,
	output logic write_gate_out,
	output logic controller_sync_clock_out,
	output logic buffer_capture_clock_out,
	output logic [15:0] data_buffer_out,
	output logic seek_go_out,
	output logic sector_found_out,
	output logic read_enable_flag_out,
	output logic header_area_flag_out
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [4:0] sync1_reg, sync2_reg, sync3_reg;
	logic [4:0] sync_next;
	always_comb
	begin
		sync_next = {sector_pulse_in, byte_clock_in, controller_write_clock_in,
			cyl_advance_in, 1'b0};
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			sync3_reg <= 5'h00;
		end
		else
		begin
			sync1_reg <= sync_next;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	logic sect_evt, byte_evt, wclk_evt, adv_evt;
	assign sect_evt = sync2_reg[4] & ~sync3_reg[4];
	assign byte_evt = sync2_reg[3] & ~sync3_reg[3];
	assign wclk_evt = sync2_reg[2] & ~sync3_reg[2];
	assign adv_evt = sync2_reg[1] & ~sync3_reg[1];
	logic [7:0] rd_byte1_reg, rd_byte2_reg;
	logic [15:0] dl1_reg, dl2_reg;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			rd_byte1_reg <= 8'h00;
			rd_byte2_reg <= 8'h00;
			dl1_reg <= 16'h0000;
			dl2_reg <= 16'h0000;
		end
		else
		begin
			rd_byte1_reg <= read_byte_in;
			rd_byte2_reg <= rd_byte1_reg;
			dl1_reg <= data_lines_in;
			dl2_reg <= dl1_reg;
		end
	end
	// ****************************************
	// Register file and Wishbone slave
	// ****************************************
	logic [9:0] desired_cylinder_reg, desired_cylinder_next;
	logic [4:0] desired_sector_reg, desired_sector_next;
	logic [4:0] desired_track_reg, desired_track_next;
	logic format18_reg, format18_next;
	dsf_cmd_t cmd_reg, cmd_next;
	logic search_reg, search_next;
	logic seek_go_reg, seek_go_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [4:0] sect_cnt_reg, sect_cnt_next;
	logic sector_found_reg;
	logic read_enable_flag_reg, sync_strobe_reg, header_area_flag_reg, fmt_flag_reg;
	dsf_state_t state_reg;
	logic wb_req, wb_wr;
	logic [31:0] status_word;
	assign wb_req = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign wb_wr = wb_req & wb_we_in & wb_sel_in[0];
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[7:0] = state_reg;
		status_word[12:8] = sect_cnt_reg;
		status_word[16] = sector_found_reg;
		status_word[17] = header_area_flag_reg;
		status_word[18] = read_enable_flag_reg;
		status_word[19] = fmt_flag_reg;
	end
	always_comb
	begin
		desired_cylinder_next = desired_cylinder_reg;
		desired_sector_next = desired_sector_reg;
		desired_track_next = desired_track_reg;
		format18_next = format18_reg;
		cmd_next = cmd_reg;
		search_next = search_reg;
		seek_go_next = 1'b0;
		ack_next = wb_req;
		rdat_next = 32'h0000_0000;
		if (wb_wr && wb_adr_in == DSF_ADDR_CYL && wb_dat_in[9:0] <= DSF_CYL_MAX)
		begin
			desired_cylinder_next = {1'b0, wb_dat_in[8:0]};
		end
		if (wb_wr && wb_adr_in == DSF_ADDR_SECTRK)
		begin
			desired_sector_next = wb_dat_in[DSF_SEC_LO +: 5];
			desired_track_next = wb_dat_in[DSF_TRK_LO +: 5];
			format18_next = wb_dat_in[16];
		end
		if (wb_wr && wb_adr_in == DSF_ADDR_CMD)
		begin
			cmd_next = '{format: wb_dat_in[5:0] == DSF_CMD_FORMAT,
				wr_data: wb_dat_in[5:0] == DSF_CMD_WRITE,
				rd_hdr: wb_dat_in[5:0] == DSF_CMD_READ_HDR,
				rd_data: wb_dat_in[5:0] == DSF_CMD_READ};
			search_next = wb_dat_in[5:0] == DSF_CMD_SEARCH;
			seek_go_next = (wb_dat_in[5:0] == DSF_CMD_SEEK) || (wb_dat_in[5:0] == DSF_CMD_FORMAT)
				|| (wb_dat_in[5:0] == DSF_CMD_WRITE) || (wb_dat_in[5:0] == DSF_CMD_READ_HDR)
				|| (wb_dat_in[5:0] == DSF_CMD_READ);
		end
		if (adv_evt)
		begin
			desired_cylinder_next = (desired_cylinder_reg == DSF_CYL_MAX) ? 10'h000
				: desired_cylinder_reg + 10'h001;
			seek_go_next = 1'b1;
		end
		if (state_reg == DSF_TOL && sect_evt && search_reg && sector_found_reg)
		begin
			search_next = 1'b0;
		end
		if (wb_req && !wb_we_in)
		begin
			case (wb_adr_in)
				DSF_ADDR_CMD: rdat_next = {26'h0, search_reg, cmd_reg, 1'b0};
				DSF_ADDR_CYL: rdat_next = {22'h0, desired_cylinder_reg};
				DSF_ADDR_SECTRK: rdat_next = {15'h0, format18_reg, 3'h0, desired_track_reg,
					3'h0, desired_sector_reg};
				DSF_ADDR_STATUS: rdat_next = status_word;
				default: rdat_next = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			desired_cylinder_reg <= 10'h000;
			desired_sector_reg <= 5'h00;
			desired_track_reg <= 5'h00;
			format18_reg <= 1'b0;
			cmd_reg <= '0;
			search_reg <= 1'b0;
			seek_go_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end
		else
		begin
			desired_cylinder_reg <= desired_cylinder_next;
			desired_sector_reg <= desired_sector_next;
			desired_track_reg <= desired_track_next;
			format18_reg <= format18_next;
			cmd_reg <= cmd_next;
			search_reg <= search_next;
			seek_go_reg <= seek_go_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end
	// ****************************************
	// Sector sequencer
	// ****************************************
	dsf_state_t state_next;
	logic [9:0] byte_cnt_reg, byte_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [15:0] buffer_reg, buffer_next;
	logic sector_found_next, read_enable_flag_next, sync_strobe_next;
	logic header_area_flag_next, fmt_flag_next;
	logic sync_clk_reg, sync_clk_next, buf_clk_reg, buf_clk_next;
	logic wgate_reg, wgate_next, word_pending_reg, word_pending_next;
	logic active, writing;
	logic [4:0] sect_limit;
	logic [9:0] data_bytes;
	assign active = cmd_reg.format | cmd_reg.wr_data | cmd_reg.rd_hdr | cmd_reg.rd_data | search_reg;
	assign writing = cmd_reg.format | cmd_reg.wr_data;
	assign sect_limit = format18_reg ? DSF_SECT_18 : DSF_SECT_16;
	assign data_bytes = {DSF_DATA_WORDS[8:0], 1'b0};
	always_comb
	begin
		state_next = state_reg;
		byte_cnt_next = byte_cnt_reg;
		shift_next = shift_reg;
		buffer_next = buffer_reg;
		sect_cnt_next = sect_cnt_reg;
		sector_found_next = sector_found_reg;
		read_enable_flag_next = read_enable_flag_reg;
		sync_strobe_next = sync_strobe_reg;
		header_area_flag_next = header_area_flag_reg;
		fmt_flag_next = fmt_flag_reg;
		sync_clk_next = sync_clk_reg;
		buf_clk_next = 1'b0;
		wgate_next = wgate_reg;
		word_pending_next = word_pending_reg;
		if (wclk_evt && sync_clk_reg)
		begin
			buffer_next = dl2_reg;
			sync_clk_next = 1'b0;
			word_pending_next = 1'b1;
		end
		if (sect_evt)
		begin
			sect_cnt_next = (sect_cnt_reg + 5'h01 >= sect_limit) ? 5'h00
				: sect_cnt_reg + 5'h01;
			byte_cnt_next = 10'h000;
			shift_next = 8'h00;
			header_area_flag_next = 1'b0;
			read_enable_flag_next = 1'b0;
			sync_strobe_next = 1'b0;
			if (cmd_reg.format)
			begin
				sector_found_next = 1'b1;
				fmt_flag_next = 1'b1;
				sync_clk_next = 1'b1;
				wgate_next = 1'b1;
				state_next = DSF_PRE;
			end
			else if (active)
			begin
				sector_found_next = (sect_cnt_next == desired_sector_reg);
				fmt_flag_next = 1'b0;
				wgate_next = 1'b0;
				state_next = (sect_cnt_next == desired_sector_reg && !search_reg)
					? DSF_PRE : DSF_IDLE;
			end
			else
			begin
				state_next = DSF_IDLE;
			end
		end
		else if (byte_evt && state_reg != DSF_IDLE)
		begin
			byte_cnt_next = byte_cnt_reg + 10'h001;
			shift_next = 8'h00;
			case (state_reg)
				DSF_PRE:
				begin
					if (cmd_reg.format && byte_cnt_reg == DSF_BYTE_PRE_SYNC - 10'h001)
					begin
						shift_next = DSF_SYNC_BYTE;
						byte_cnt_next = 10'h000;
						buf_clk_next = 1'b1;
						state_next = DSF_HDR;
					end
					else if (!cmd_reg.format && byte_cnt_reg == DSF_BYTE_ARM)
					begin
						read_enable_flag_next = 1'b1;
						sync_strobe_next = 1'b1;
					end
					if (!cmd_reg.format && sync_strobe_reg && rd_byte2_reg == DSF_SYNC_BYTE)
					begin
						header_area_flag_next = 1'b1;
						byte_cnt_next = 10'h000;
						state_next = DSF_HDR;
					end
				end
				DSF_HDR:
				begin
					header_area_flag_next = 1'b1;
					if (cmd_reg.format)
					begin
						shift_next = byte_cnt_reg[0] ? buffer_reg[7:0] : buffer_reg[15:8];
						if (byte_cnt_reg[0] && word_pending_reg && byte_cnt_reg < 10'h007)
						begin
							sync_clk_next = 1'b1;
							word_pending_next = 1'b0;
						end
					end
					else if (byte_cnt_reg[0])
					begin
						buffer_next = {buffer_reg[15:8], rd_byte2_reg};
					end
					else
					begin
						buffer_next = {rd_byte2_reg, buffer_reg[7:0]};
					end
					if (byte_cnt_next == DSF_HDR_BYTES)
					begin
						byte_cnt_next = 10'h000;
						header_area_flag_next = 1'b0;
						state_next = DSF_HGAP;
					end
				end
				DSF_HGAP:
				begin
					if (byte_cnt_reg == DSF_HDR_GAP_ZEROS)
					begin
						shift_next = DSF_SYNC_BYTE;
						byte_cnt_next = 10'h000;
						state_next = DSF_DATA;
					end
				end
				DSF_DATA:
				begin
					if (byte_cnt_next == data_bytes)
					begin
						byte_cnt_next = 10'h000;
						state_next = DSF_ECC;
					end
				end
				DSF_ECC:
				begin
					if (byte_cnt_next == DSF_ECC_BYTES)
					begin
						byte_cnt_next = 10'h000;
						state_next = DSF_DGAP;
					end
				end
				DSF_DGAP:
				begin
					if (byte_cnt_next == DSF_DGAP_BYTES)
					begin
						byte_cnt_next = 10'h000;
						wgate_next = 1'b0;
						state_next = DSF_TOL;
					end
				end
				DSF_TOL:
				begin
					if (byte_cnt_next == DSF_TOL_BYTES)
					begin
						state_next = DSF_IDLE;
					end
				end
				default: state_next = DSF_IDLE;
			endcase
			if (!writing)
			begin
				wgate_next = 1'b0;
			end
		end
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state_reg <= DSF_IDLE;
			byte_cnt_reg <= 10'h000;
			shift_reg <= 8'h00;
			buffer_reg <= 16'h0000;
			sect_cnt_reg <= 5'h00;
			sector_found_reg <= 1'b0;
			read_enable_flag_reg <= 1'b0;
			sync_strobe_reg <= 1'b0;
			header_area_flag_reg <= 1'b0;
			fmt_flag_reg <= 1'b0;
			sync_clk_reg <= 1'b0;
			buf_clk_reg <= 1'b0;
			wgate_reg <= 1'b0;
			word_pending_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			byte_cnt_reg <= byte_cnt_next;
			shift_reg <= shift_next;
			buffer_reg <= buffer_next;
			sect_cnt_reg <= sect_cnt_next;
			sector_found_reg <= sector_found_next;
			read_enable_flag_reg <= read_enable_flag_next;
			sync_strobe_reg <= sync_strobe_next;
			header_area_flag_reg <= header_area_flag_next;
			fmt_flag_reg <= fmt_flag_next;
			sync_clk_reg <= sync_clk_next;
			buf_clk_reg <= buf_clk_next;
			wgate_reg <= wgate_next;
			word_pending_reg <= word_pending_next;
		end
	end
	assign wb_dat_out = rdat_reg;
	assign wb_ack_out = ack_reg;
	assign write_byte_out = shift_reg;
	assign write_gate_out = wgate_reg;
	assign controller_sync_clock_out = sync_clk_reg;
	assign buffer_capture_clock_out = buf_clk_reg;
	assign data_buffer_out = buffer_reg;
	assign seek_go_out = seek_go_reg;
	assign sector_found_out = sector_found_reg;
	assign read_enable_flag_out = read_enable_flag_reg;
	assign header_area_flag_out = header_area_flag_reg;
	// ****************************************
	// Checks
	// ****************************************
	property p_fmt_sect;
		@(posedge clock_in) disable iff (rst_in)
		(sect_evt && cmd_reg.format) |=> (sector_found_reg && fmt_flag_reg && shift_reg == 8'h00
			&& byte_cnt_reg == 10'h000);
	endproperty
	a_fmt_sect: assert property (p_fmt_sect) else $error("format sector pulse effects missing");
	property p_match;
		@(posedge clock_in) disable iff (rst_in)
		(sect_evt && !cmd_reg.format && active) |=> (sector_found_reg == (sect_cnt_reg == desired_sector_reg));
	endproperty
	a_match: assert property (p_match) else $error("sector found not tied to compare");
	property p_sync39;
		@(posedge clock_in) disable iff (rst_in)
		(byte_evt && !sect_evt && state_reg == DSF_PRE && cmd_reg.format
			&& byte_cnt_reg == 10'h026) |=> (shift_reg == DSF_SYNC_BYTE && byte_cnt_reg == 10'h000
			&& buffer_capture_clock_out);
	endproperty
	a_sync39: assert property (p_sync39) else $error("sync byte not inserted at 39");
	property p_bufpulse;
		@(posedge clock_in) disable iff (rst_in)
		buf_clk_reg |=> !buf_clk_reg;
	endproperty
	a_bufpulse: assert property (p_bufpulse) else $error("buffer clock longer than one cycle");
	property p_arm;
		@(posedge clock_in) disable iff (rst_in)
		(byte_evt && !sect_evt && state_reg == DSF_PRE && !cmd_reg.format
			&& byte_cnt_reg == 10'h01e) |=> (read_enable_flag_reg && sync_strobe_reg);
	endproperty
	a_arm: assert property (p_arm) else $error("read enable not set at byte 30");
	property p_hdr;
		@(posedge clock_in) disable iff (rst_in)
		($rose(header_area_flag_reg) && !cmd_reg.format) |-> (state_reg == DSF_HDR
			&& byte_cnt_reg == 10'h000 && $past(rd_byte2_reg) == 8'h98);
	endproperty
	a_hdr: assert property (p_hdr) else $error("header area without sync detection");
	property p_cyl;
		@(posedge clock_in) disable iff (rst_in)
		desired_cylinder_reg <= 10'h19a;
	endproperty
	a_cyl: assert property (p_cyl) else $error("cylinder beyond range");
	property p_sect18;
		@(posedge clock_in) disable iff (rst_in)
		(sect_evt && format18_reg) |=> (sect_cnt_reg < 5'h14);
	endproperty
	a_sect18: assert property (p_sect18) else $error("sector count beyond 20");
endmodule

// *** tb/dsf_ctrl_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Controller answering header word requests
// ****************************************
module dsf_ctrl_model
(
	input wire logic clock_in,
	input wire logic sync_clock_in,
	input wire logic [15:0] word_in,
	input wire logic [3:0] delay_in,
	output logic [15:0] data_lines_out,
	output logic write_clock_out
);
	int wait_cnt = 0;
	initial data_lines_out = 16'h0000;
	initial write_clock_out = 1'b0;
	// Word on the lines first, then write clock, held until sync clock falls
	always @(posedge clock_in)
	begin
		if (!sync_clock_in)
		begin
			wait_cnt <= 0;
			if (write_clock_out)
				data_lines_out <= ~data_lines_out;
			write_clock_out <= 1'b0;
		end
		else if (wait_cnt < int'(delay_in))
		begin
			data_lines_out <= word_in;
			wait_cnt <= wait_cnt + 1;
		end
		else
			write_clock_out <= 1'b1;
	end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import dsf_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] wb_adr_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h0;
	logic [3:0] wb_sel_in = 4'h0;
	logic wb_we_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
	logic [31:0] wb_dat_out, rd;
	logic wb_ack_out;
	logic sector_pulse_in = 1'b0, byte_clock_in = 1'b0, cyl_advance_in = 1'b0;
	logic controller_write_clock_in;
	logic [7:0] read_byte_in = 8'h00;
	logic [15:0] data_lines_in, data_buffer_out;
	logic [15:0] word = 16'h0000;
	logic [3:0] dly = 4'h1;
	logic [7:0] write_byte_out;
	logic write_gate_out, controller_sync_clock_out, buffer_capture_clock_out;
	logic seek_go_out, sector_found_out, read_enable_flag_out, header_area_flag_out;
	int num_errors = 0, n_checks = 0, seeks = 0, bufs = 0, s0, cyl;
	// Reference sector counter: one step per sector pulse, wrapping at the track's sector count
	int exp_sect = 0, sect_lim = 22;
	logic [31:0] st;
	logic [31:0] cmds [5] = '{DSF_CMD_SEEK, DSF_CMD_FORMAT, DSF_CMD_WRITE,
		DSF_CMD_READ_HDR, DSF_CMD_READ};
	logic [31:0] cmd_rb [5] = '{32'h0, 32'h10, 32'h08, 32'h04, 32'h02};

	dsf_sequencer dsf_sequencer_i (.clock_in, .rst_in, .wb_adr_in, .wb_dat_in,
		.wb_sel_in, .wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out,
		.sector_pulse_in, .byte_clock_in, .read_byte_in, .data_lines_in,
		.controller_write_clock_in, .cyl_advance_in, .write_byte_out,
		.write_gate_out, .controller_sync_clock_out, .buffer_capture_clock_out,
		.data_buffer_out, .seek_go_out, .sector_found_out, .read_enable_flag_out,
		.header_area_flag_out);
	dsf_ctrl_model dsf_ctrl_model_i (.clock_in, .sync_clock_in(controller_sync_clock_out),
		.word_in(word), .delay_in(dly), .data_lines_out(data_lines_in),
		.write_clock_out(controller_write_clock_in));

	always #12.5 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		if (seek_go_out === 1'b1)
			seeks++;
		if (buffer_capture_clock_out === 1'b1)
			bufs++;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic do_reset();
		exp_sect = 0;
		sect_lim = 22;
		rst_in <= 1'b1;
		cycles(10);
		rst_in <= 1'b0;
		cycles(2);
	endtask
	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		wb_adr_in <= a;
		wb_we_in <= w;
		wb_dat_in <= d;
		wb_sel_in <= 4'hf;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		@(posedge clock_in);
		while (wb_ack_out !== 1'b1 && t < 50)
		begin
			@(posedge clock_in);
			t++;
		end
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		@(posedge clock_in);
		if (t >= 50)
			check("ack", 0, 1);
	endtask
	// Link clock period of 200 ns
	task automatic byte_clk(input logic [7:0] b);
		read_byte_in <= b;
		byte_clock_in <= 1'b1;
		cycles(4);
		byte_clock_in <= 1'b0;
		cycles(4);
	endtask
	task automatic sect_pulse();
		sector_pulse_in <= 1'b1;
		cycles(4);
		sector_pulse_in <= 1'b0;
		cycles(8);
		exp_sect = (exp_sect + 1) % sect_lim;
	endtask

	initial
	begin
		void'($urandom(58536));
		do_reset();
		wb(DSF_ADDR_STATUS, 0, 0);
		check("status", rd, 32'h0000_0001);
		wb(4'h2, 0, 0);
		check("unmapped", rd, 0);
		wb(DSF_ADDR_CYL, 1, 32'd410);
		wb(DSF_ADDR_CYL, 1, 32'd411);
		wb(DSF_ADDR_CYL, 0, 0);
		check("cyl max", rd, 32'd410);
		cyl = $urandom_range(409, 0);
		wb(DSF_ADDR_CYL, 1, cyl);
		cyl_advance_in <= 1'b1;
		cycles(6);
		cyl_advance_in <= 1'b0;
		cycles(6);
		wb(DSF_ADDR_CYL, 0, 0);
		check("cyl adv", rd, cyl + 1);
		for (int i = 0; i < 5; i++)
		begin
			s0 = seeks;
			wb(DSF_ADDR_CMD, 1, cmds[i]);
			cycles(4);
			check("seek go", seeks, s0 + 1);
			wb(DSF_ADDR_CMD, 0, 0);
			check("cmd", rd, cmd_rb[i]);
		end
		s0 = seeks;
		wb(DSF_ADDR_CMD, 1, DSF_CMD_SEARCH);
		cycles(4);
		check("search go", seeks, s0);
		wb(DSF_ADDR_CMD, 0, 0);
		check("search cmd", rd, 32'h0000_0020);
		// ****************************************
		// Formatting
		// ****************************************
		do_reset();
		word = 16'($urandom);
		dly = 4'($urandom_range(12, 1));
		wb(DSF_ADDR_CMD, 1, DSF_CMD_FORMAT);
		sect_pulse();
		check("zero byte", write_byte_out, 0);
		check("found", sector_found_out, 1);
		wb(DSF_ADDR_STATUS, 0, 0);
		check("fmt flag", rd[19], 1);
		cycles(30);
		check("sync clk", controller_sync_clock_out, 0);
		for (int i = 1; i <= 39; i++)
		begin
			s0 = bufs;
			byte_clk(8'h00);
			check("gate", write_gate_out, 1);
			check("pre byte", write_byte_out, i < 39 ? 8'h00 : DSF_SYNC_BYTE);
			check("buf clk", bufs - s0, i == 39);
		end
		check("buffer", data_buffer_out, word);
		byte_clk(8'h00);
		check("hdr hi", write_byte_out, word[15:8]);
		// ****************************************
		// Reading
		// ****************************************
		do_reset();
		st = {15'h0, 1'b1, 3'h0, 5'($urandom_range(18, 0)), 8'h02};
		sect_lim = 20;
		wb(DSF_ADDR_SECTRK, 1, st);
		wb(DSF_ADDR_SECTRK, 0, 0);
		check("sectrk", rd, st);
		wb(DSF_ADDR_CMD, 1, DSF_CMD_READ);
		for (int p = 1; p <= 2; p++)
		begin
			sect_pulse();
			wb(DSF_ADDR_STATUS, 0, 0);
			check("sect cnt", rd[12:8], exp_sect);
			check("found", sector_found_out, p == 2);
		end
		for (int i = 1; i <= 31; i++)
		begin
			byte_clk({1'b0, 7'($urandom)});
			if (i >= 30)
				check("rd en", read_enable_flag_out, i == 31);
		end
		check("hdr area", header_area_flag_out, 0);
		byte_clk(DSF_SYNC_BYTE);
		check("hdr area", header_area_flag_out, 1);
		repeat (19) sect_pulse();
		wb(DSF_ADDR_STATUS, 0, 0);
		check("sect wrap", rd[12:8], exp_sect);
		check("found", sector_found_out, exp_sect == 2);
		complete_run();
	end

	initial
	begin
		#500000;
		num_errors++;
		complete_run();
	end
endmodule
